// *** pkg/eag_pkg.sv ***
// eag_pkg: addressing mode codes, controller states and cost figures
// assumes: shared by the address generator top and its cost table
package eag_pkg;

	// ****************************************
	// modes and states
	// ****************************************
	typedef enum logic [3:0] {
		M_DILY = 4'h0,
		M_DIL  = 4'h1,
		M_DI   = 4'h2,
		M_DIR  = 4'h3,
		M_IMM  = 4'h4,
		M_IMP  = 4'h5,
		M_RELL = 4'h6,
		M_REL  = 4'h7,
		M_STK  = 4'h8,
		M_SR   = 4'h9,
		M_SRIY = 4'ha,
		M_AIXJ = 4'hb,
		M_ABSX = 4'hc
	} eag_mode_e;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FETCH = 3'b010,
		S_FIN   = 3'b100
	} eag_state_e;

	// ****************************************
	// base cycles and bytes per mode
	// ****************************************
	localparam logic [3:0] CYC_DILY = 4'h6;
	localparam logic [3:0] CYC_DIL  = 4'h6;
	localparam logic [3:0] CYC_DI   = 4'h5;
	localparam logic [3:0] CYC_DIR  = 4'h3;
	localparam logic [3:0] CYC_IMM  = 4'h2;
	localparam logic [3:0] CYC_IMP  = 4'h2;
	localparam logic [3:0] CYC_RELL = 4'h3;
	localparam logic [3:0] CYC_REL  = 4'h2;
	localparam logic [3:0] CYC_STK  = 4'h3;
	localparam logic [3:0] CYC_SR   = 4'h4;
	localparam logic [3:0] CYC_SRIY = 4'h7;
	localparam logic [3:0] CYC_AIXJ = 4'h6;
	localparam logic [3:0] CYC_ABSX = 4'h4;
	localparam logic [2:0] BYT_ONE  = 3'h1;
	localparam logic [2:0] BYT_TWO  = 3'h2;
	localparam logic [2:0] BYT_THR  = 3'h3;

	// ****************************************
	// penalties and fixed values
	// ****************************************
	localparam logic [3:0] CYC_PEN    = 4'h1;
	localparam logic [3:0] CYC_RMW8   = 4'h2;
	localparam logic [3:0] CYC_RMW16  = 4'h3;
	localparam logic [3:0] CYC_STA_M8 = 4'h5;
	localparam logic [2:0] BYT_PEN    = 3'h1;
	localparam logic [7:0] BANK_ZERO  = 8'h00;
	localparam logic [1:0] PTR_SHORT  = 2'h2;
	localparam logic [1:0] PTR_LONG   = 2'h3;
	localparam logic [23:0] EA_RST    = 24'h000000;
	localparam logic [15:0] W16_RST   = 16'h0000;
	localparam logic [3:0] CYC_RST    = 4'h0;
	localparam logic [2:0] BYT_RST    = 3'h0;

endpackage

// *** pkg/eag_cost_if.sv ***
// eag_cost_if: carries one instruction's cost inputs and results
// assumes: driven by the top, answered combinationally by eag_cost
`timescale 1ns/1ps
interface eag_cost_if;
	eag_pkg::eag_mode_e mode;
	logic               wide;
	logic               m_flag;
	logic               dl_nz;
	logic               page_x;
	logic               taken;
	logic               rmw;
	logic               store_acc;
	logic [2:0]         stk_extra;
	logic [3:0]         cycles;
	logic [2:0]         bytes;

	modport calc (
		input  mode, wide, m_flag, dl_nz, page_x, taken, rmw, store_acc, stk_extra,
		output cycles, bytes
	);
	modport user (
		output mode, wide, m_flag, dl_nz, page_x, taken, rmw, store_acc, stk_extra,
		input  cycles, bytes
	);
endinterface

// *** verilog/eag_cost.sv ***
// eag_cost: cycle and byte count of one instruction from its mode
// assumes: inputs are stable registered values of the requesting top
`timescale 1ns/1ps
module eag_cost (
	// cost carrier
	eag_cost_if.calc c
);
	logic [3:0] base;
	logic [2:0] byt;
	logic       dp;
	logic       w_ok;
	logic [3:0] cyc;

	always_comb begin
		base = eag_pkg::CYC_IMP;
		byt  = eag_pkg::BYT_ONE;
		dp   = 1'b0;
		w_ok = 1'b0;
		case (c.mode)
			eag_pkg::M_DILY: begin base = eag_pkg::CYC_DILY; byt = eag_pkg::BYT_TWO; dp = 1'b1; w_ok = 1'b1; end
			eag_pkg::M_DIL:  begin base = eag_pkg::CYC_DIL;  byt = eag_pkg::BYT_TWO; dp = 1'b1; w_ok = 1'b1; end
			eag_pkg::M_DI:   begin base = eag_pkg::CYC_DI;   byt = eag_pkg::BYT_TWO; dp = 1'b1; w_ok = 1'b1; end
			eag_pkg::M_DIR:  begin base = eag_pkg::CYC_DIR;  byt = eag_pkg::BYT_TWO; dp = 1'b1; w_ok = 1'b1; end
			eag_pkg::M_IMM:  begin base = eag_pkg::CYC_IMM;  byt = eag_pkg::BYT_TWO; w_ok = 1'b1; end
			eag_pkg::M_IMP:  begin base = eag_pkg::CYC_IMP;  byt = eag_pkg::BYT_ONE; end
			eag_pkg::M_RELL: begin base = eag_pkg::CYC_RELL; byt = eag_pkg::BYT_THR; end
			eag_pkg::M_REL:  begin base = eag_pkg::CYC_REL;  byt = eag_pkg::BYT_TWO; end
			eag_pkg::M_STK:  begin base = eag_pkg::CYC_STK + {1'b0, c.stk_extra}; end
			eag_pkg::M_SR:   begin base = eag_pkg::CYC_SR;   byt = eag_pkg::BYT_TWO; w_ok = 1'b1; end
			eag_pkg::M_SRIY: begin base = eag_pkg::CYC_SRIY; byt = eag_pkg::BYT_TWO; w_ok = 1'b1; end
			eag_pkg::M_AIXJ: begin base = eag_pkg::CYC_AIXJ; byt = eag_pkg::BYT_THR; end
			eag_pkg::M_ABSX: begin base = eag_pkg::CYC_ABSX; byt = eag_pkg::BYT_THR; w_ok = 1'b1; end
			default:         begin base = eag_pkg::CYC_IMP;  byt = eag_pkg::BYT_ONE; end
		endcase
	end

	always_comb begin
		cyc = base;
		if (w_ok && c.wide) begin
			cyc = cyc + eag_pkg::CYC_PEN;
		end
		if (dp && c.dl_nz) begin
			cyc = cyc + eag_pkg::CYC_PEN;
		end
		if (c.mode == eag_pkg::M_ABSX && c.page_x) begin
			cyc = cyc + eag_pkg::CYC_PEN;
		end
		if ((c.mode == eag_pkg::M_REL || c.mode == eag_pkg::M_RELL) && c.taken) begin
			cyc = cyc + eag_pkg::CYC_PEN;
		end
		if (c.rmw && (c.mode == eag_pkg::M_DIR || c.mode == eag_pkg::M_ABSX)) begin
			cyc = cyc + (c.m_flag ? eag_pkg::CYC_RMW8 : eag_pkg::CYC_RMW16);
		end
		// an absolute indexed store never re-reads, so with an 8-bit accumulator its cost is fixed;
		// applied last so a stray rmw request cannot stretch it
		if (c.mode == eag_pkg::M_ABSX && c.store_acc && c.m_flag) begin
			cyc = eag_pkg::CYC_STA_M8;
		end
	end

	assign c.cycles = cyc;
	assign c.bytes  = (c.mode == eag_pkg::M_IMM && c.wide) ? byt + eag_pkg::BYT_PEN : byt;

endmodule

// *** verilog/eag_top.sv ***
// eag_top: effective address, branch target and cost generator
// assumes: all inputs come from core logic on ref_clk; pointer bytes are
// read through a one-byte request/acknowledge port to the bus sequencer
`timescale 1ns/1ps

module eag_top (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// instruction request
	input  wire logic               req_valid,
	input  wire eag_pkg::eag_mode_e req_mode,
	input  wire logic [7:0]         req_byte2,
	input  wire logic [7:0]         req_byte3,
	input  wire logic               req_idx_width,
	input  wire logic               req_rmw,
	input  wire logic               req_store_acc_op,
	input  wire logic               req_taken,
	input  wire logic               req_push_relative_op,
	input  wire logic [2:0]         req_stack_extra,
	// processor state
	input  wire logic [15:0]        direct_base,
	input  wire logic [15:0]        index_x,
	input  wire logic [15:0]        index_y,
	input  wire logic [15:0]        stack_ptr,
	input  wire logic [15:0]        prog_counter,
	input  wire logic [7:0]         data_bank_register,
	input  wire logic [7:0]         program_bank_register,
	input  wire logic               m_flag,
	input  wire logic               x_flag,
	// pointer read port
	output logic                    mem_req,
	output logic [23:0]             mem_addr,
	input  wire logic               mem_ack,
	input  wire logic [7:0]         mem_rdata,
	// results
	output logic                    busy,
	output logic                    done,
	output logic [23:0]             eff_addr,
	output logic [15:0]             operand,
	output logic [15:0]             new_pc,
	output logic                    load_pc,
	output logic                    push_req,
	output logic [3:0]              cycles,
	output logic [2:0]              bytes
);

	// ****************************************
	// request capture
	// ****************************************
	eag_pkg::eag_state_e st_r;
	eag_pkg::eag_mode_e  mode_r;
	logic [7:0]  b2_r, b3_r, dbr_r, pbr_r;
	logic [15:0] d_r, x_r, y_r, s_r, pc_r;
	logic        wide_r, m_r, rmw_r, sta_r, tkn_r, psh_r;
	logic [2:0]  sx_r;
	logic [15:0] ptr_r;
	logic [1:0]  cnt_r, need_r;
	logic [23:0] fch_r;
	logic        mem_req_r, busy_r, done_r, load_pc_r, push_r;
	logic [23:0] mem_addr_r, ea_r;
	logic [15:0] opnd_r, npc_r;
	logic [3:0]  cyc_r;
	logic [2:0]  byt_r;
	logic        take;
	logic        fetch_mode;
	logic [15:0] ptr_nxt;
	logic [1:0]  need_nxt;

	assign take = (st_r == eag_pkg::S_IDLE) && req_valid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= eag_pkg::M_IMP;
			b2_r   <= 8'h00;
			b3_r   <= 8'h00;
			dbr_r  <= 8'h00;
			pbr_r  <= 8'h00;
			d_r    <= eag_pkg::W16_RST;
			x_r    <= eag_pkg::W16_RST;
			y_r    <= eag_pkg::W16_RST;
			s_r    <= eag_pkg::W16_RST;
			pc_r   <= eag_pkg::W16_RST;
			wide_r <= 1'b0;
			m_r    <= 1'b1;
			rmw_r  <= 1'b0;
			sta_r  <= 1'b0;
			tkn_r  <= 1'b0;
			psh_r  <= 1'b0;
			sx_r   <= 3'h0;
		end else if (take) begin
			mode_r <= req_mode;
			b2_r   <= req_byte2;
			b3_r   <= req_byte3;
			dbr_r  <= data_bank_register;
			pbr_r  <= program_bank_register;
			d_r    <= direct_base;
			x_r    <= index_x;
			y_r    <= index_y;
			s_r    <= stack_ptr;
			pc_r   <= prog_counter;
			// the width that counts is chosen per instruction by the core
			wide_r <= req_idx_width ? !x_flag : !m_flag;
			m_r    <= m_flag;
			rmw_r  <= req_rmw;
			sta_r  <= req_store_acc_op;
			tkn_r  <= req_taken;
			psh_r  <= req_push_relative_op;
			sx_r   <= req_stack_extra;
		end
	end

	// ****************************************
	// pointer location
	// ****************************************
	always_comb begin
		fetch_mode = 1'b1;
		need_nxt   = eag_pkg::PTR_SHORT;
		ptr_nxt    = eag_pkg::W16_RST;
		case (req_mode)
			eag_pkg::M_DILY, eag_pkg::M_DIL: begin
				ptr_nxt  = direct_base + {8'h00, req_byte2};
				need_nxt = eag_pkg::PTR_LONG;
			end
			eag_pkg::M_DI:   ptr_nxt = direct_base + {8'h00, req_byte2};
			eag_pkg::M_SRIY: ptr_nxt = stack_ptr + {8'h00, req_byte2};
			eag_pkg::M_AIXJ: ptr_nxt = {req_byte3, req_byte2} + index_x;
			default:         fetch_mode = 1'b0;
		endcase
	end

	// ****************************************
	// controller
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= eag_pkg::S_IDLE;
		end else begin
			case (st_r)
				eag_pkg::S_IDLE: begin
					if (req_valid) begin
						st_r <= fetch_mode ? eag_pkg::S_FETCH : eag_pkg::S_FIN;
					end
				end
				eag_pkg::S_FETCH: begin
					if (mem_ack && cnt_r == need_r - 2'h1) begin
						st_r <= eag_pkg::S_FIN;
					end
				end
				eag_pkg::S_FIN:   st_r <= eag_pkg::S_IDLE;
				default:          st_r <= eag_pkg::S_IDLE;
			endcase
		end
	end

	// pointer bytes are read lowest first and wrap inside bank zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_r      <= eag_pkg::W16_RST;
			cnt_r      <= 2'h0;
			need_r     <= eag_pkg::PTR_SHORT;
			fch_r      <= eag_pkg::EA_RST;
			mem_req_r  <= 1'b0;
			mem_addr_r <= eag_pkg::EA_RST;
		end else if (take && fetch_mode) begin
			ptr_r      <= ptr_nxt;
			cnt_r      <= 2'h0;
			need_r     <= need_nxt;
			fch_r      <= eag_pkg::EA_RST;
			mem_req_r  <= 1'b1;
			mem_addr_r <= {eag_pkg::BANK_ZERO, ptr_nxt};
		end else if (st_r == eag_pkg::S_FETCH && mem_ack) begin
			fch_r[cnt_r*8 +: 8] <= mem_rdata;
			cnt_r      <= cnt_r + 2'h1;
			mem_req_r  <= (cnt_r != need_r - 2'h1);
			mem_addr_r <= {eag_pkg::BANK_ZERO, ptr_r + {14'h0000, cnt_r} + 16'h0001};
		end
	end

	// ****************************************
	// address and target forming
	// ****************************************
	logic [23:0] ea_c;
	logic [15:0] npc_c, opnd_c, absx_lo;
	logic        ld_c, push_c, page_c;

	assign absx_lo = {b3_r, b2_r} + x_r;
	assign page_c  = absx_lo[15:8] != b3_r;

	always_comb begin
		ea_c   = eag_pkg::EA_RST;
		npc_c  = pc_r;
		opnd_c = eag_pkg::W16_RST;
		ld_c   = 1'b0;
		push_c = 1'b0;
		case (mode_r)
			eag_pkg::M_DILY: ea_c = fch_r + {8'h00, y_r};
			eag_pkg::M_DIL:  ea_c = fch_r;
			eag_pkg::M_DI:   ea_c = {dbr_r, fch_r[15:0]};
			eag_pkg::M_DIR:  ea_c = {eag_pkg::BANK_ZERO, d_r + {8'h00, b2_r}};
			eag_pkg::M_IMM:  opnd_c = wide_r ? {b3_r, b2_r} : {8'h00, b2_r};
			eag_pkg::M_RELL: begin
				npc_c  = pc_r + {b3_r, b2_r};
				ea_c   = {pbr_r, npc_c};
				opnd_c = npc_c;
				ld_c   = !psh_r;
				push_c = psh_r;
			end
			eag_pkg::M_REL: begin
				npc_c = tkn_r ? pc_r + {{8{b2_r[7]}}, b2_r} : pc_r;
				ea_c  = {pbr_r, npc_c};
				ld_c  = tkn_r;
			end
			eag_pkg::M_STK:  ea_c = {eag_pkg::BANK_ZERO, s_r};
			eag_pkg::M_SR:   ea_c = {eag_pkg::BANK_ZERO, s_r + {8'h00, b2_r}};
			eag_pkg::M_SRIY: ea_c = {dbr_r, fch_r[15:0]} + {8'h00, y_r};
			eag_pkg::M_AIXJ: begin
				npc_c = fch_r[15:0];
				ea_c  = {pbr_r, fch_r[15:0]};
				ld_c  = 1'b1;
			end
			eag_pkg::M_ABSX: ea_c = {dbr_r, absx_lo};
			default:         ea_c = eag_pkg::EA_RST;
		endcase
	end

	// ****************************************
	// cost table
	// ****************************************
	eag_cost_if cif ();

	assign cif.mode      = mode_r;
	assign cif.wide      = wide_r;
	assign cif.m_flag    = m_r;
	assign cif.dl_nz     = d_r[7:0] != 8'h00;
	assign cif.page_x    = page_c;
	assign cif.taken     = tkn_r;
	assign cif.rmw       = rmw_r;
	assign cif.store_acc = sta_r;
	assign cif.stk_extra = sx_r;

	eag_cost u_cost (
		.c (cif.calc)
	);

	// ****************************************
	// result registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r    <= 1'b0;
			load_pc_r <= 1'b0;
			push_r    <= 1'b0;
			ea_r      <= eag_pkg::EA_RST;
			opnd_r    <= eag_pkg::W16_RST;
			npc_r     <= eag_pkg::W16_RST;
			cyc_r     <= eag_pkg::CYC_RST;
			byt_r     <= eag_pkg::BYT_RST;
		end else begin
			done_r    <= st_r == eag_pkg::S_FIN;
			load_pc_r <= (st_r == eag_pkg::S_FIN) && ld_c;
			push_r    <= (st_r == eag_pkg::S_FIN) && push_c;
			if (st_r == eag_pkg::S_FIN) begin
				ea_r   <= ea_c;
				opnd_r <= opnd_c;
				npc_r  <= npc_c;
				cyc_r  <= cif.cycles;
				byt_r  <= cif.bytes;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= take || (st_r == eag_pkg::S_FETCH) || (busy_r && st_r != eag_pkg::S_FIN);
		end
	end

	assign mem_req  = mem_req_r;
	assign mem_addr = mem_addr_r;
	assign busy     = busy_r;
	assign done     = done_r;
	assign eff_addr = ea_r;
	assign operand  = opnd_r;
	assign new_pc   = npc_r;
	assign load_pc  = load_pc_r;
	assign push_req = push_r;
	assign cycles   = cyc_r;
	assign bytes    = byt_r;

	// ****************************************
	// checks
	// ****************************************
	property p_fast_done;
		@(posedge ref_clk) disable iff (!rst_n)
		take && !fetch_mode |-> ##2 done;
	endproperty
	a_fast_done: assert property (p_fast_done) else $error("no done two cycles after request");

	property p_bank0;
		@(posedge ref_clk) disable iff (!rst_n)
		mem_req |-> mem_addr[23:16] == 8'h00;
	endproperty
	a_bank0: assert property (p_bank0) else $error("pointer read outside bank zero");

	property p_dir;
		@(posedge ref_clk) disable iff (!rst_n)
		take && req_mode == eag_pkg::M_DIR |-> ##2
		eff_addr == {8'h00, $past(direct_base, 2) + {8'h00, $past(req_byte2, 2)}};
	endproperty
	a_dir: assert property (p_dir) else $error("direct address wrong");

	property p_sr;
		@(posedge ref_clk) disable iff (!rst_n)
		take && req_mode == eag_pkg::M_SR |-> ##2
		eff_addr == {8'h00, $past(stack_ptr, 2) + {8'h00, $past(req_byte2, 2)}};
	endproperty
	a_sr: assert property (p_sr) else $error("stack relative address wrong");

	property p_imp_cost;
		@(posedge ref_clk) disable iff (!rst_n)
		take && req_mode == eag_pkg::M_IMP |-> ##2 bytes == 3'h1 && cycles == 4'h2 && !mem_req;
	endproperty
	a_imp_cost: assert property (p_imp_cost) else $error("implied cost wrong");

	property p_dily_cost;
		@(posedge ref_clk) disable iff (!rst_n)
		done && mode_r == eag_pkg::M_DILY && !wide_r && d_r[7:0] == 8'h00
		|-> cycles == 4'h6 && bytes == 3'h2;
	endproperty
	a_dily_cost: assert property (p_dily_cost) else $error("indirect long indexed cost wrong");

	property p_sriy_cost;
		@(posedge ref_clk) disable iff (!rst_n)
		done && mode_r == eag_pkg::M_SRIY |-> cycles == (wide_r ? 4'h8 : 4'h7);
	endproperty
	a_sriy_cost: assert property (p_sriy_cost) else $error("stack indirect cost wrong");

	property p_dl_pen;
		@(posedge ref_clk) disable iff (!rst_n)
		done && mode_r == eag_pkg::M_DIR && !rmw_r |-> cycles == 4'h3 + {3'h0, wide_r} + {3'h0, d_r[7:0] != 8'h00};
	endproperty
	a_dl_pen: assert property (p_dl_pen) else $error("direct alignment penalty wrong");

	property p_branch;
		@(posedge ref_clk) disable iff (!rst_n)
		done && mode_r == eag_pkg::M_REL |-> load_pc == tkn_r && cycles == (tkn_r ? 4'h3 : 4'h2);
	endproperty
	a_branch: assert property (p_branch) else $error("branch load or cost wrong");

	property p_sta;
		@(posedge ref_clk) disable iff (!rst_n)
		done && mode_r == eag_pkg::M_ABSX && sta_r && m_r |-> cycles == 4'h5;
	endproperty
	a_sta: assert property (p_sta) else $error("accumulator store cost wrong");

endmodule

// *** tb/eag_mem_model.sv ***
// eag_mem_model: memory behind the pointer read port, prompt or slow
// assumes: mem_delay picks the wait in cycles before each answer
`timescale 1ns/1ps
module eag_mem_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// pointer read port
	input  wire logic        mem_req,
	input  wire logic [23:0] mem_addr,
	output logic             mem_ack,
	output logic [7:0]       mem_rdata,
	// pacing
	input  wire logic [1:0]  mem_delay
);
	logic [1:0] wait_r;

	// bank enters the content, so a pointer read outside bank zero returns wrong bytes
	function automatic logic [7:0] byte_at(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
	endfunction

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 8'hff;
			wait_r    <= 2'h0;
		end else if (mem_req && !mem_ack && wait_r >= mem_delay) begin
			mem_ack   <= 1'b1;
			mem_rdata <= byte_at(mem_addr);
			wait_r    <= 2'h0;
		end else begin
			mem_ack   <= 1'b0;
			// data is not held past the answer cycle
			mem_rdata <= ~mem_rdata;
			if (mem_req && wait_r != 2'h3)
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for the address generator top
// assumes: eag_mem_model answers the pointer read port
`timescale 1ns/1ps
module tb;
	// ****************************************
	// signals and expectations
	// ****************************************
	logic               ref_clk = 1'b0;
	logic               rst_n, req_valid, req_idx_width, req_rmw, req_store_acc_op;
	logic               req_taken, req_push_relative_op, m_flag, x_flag;
	eag_pkg::eag_mode_e req_mode;
	logic [7:0]         req_byte2, req_byte3, data_bank_register, program_bank_register;
	logic [2:0]         req_stack_extra, bytes, e_byt;
	logic [15:0]        direct_base, index_x, index_y, stack_ptr, prog_counter;
	logic [1:0]         mem_delay;
	logic               mem_req, mem_ack, busy, done, load_pc, push_req;
	logic [23:0]        mem_addr, eff_addr, e_eff;
	logic [7:0]         mem_rdata;
	logic [15:0]        operand, new_pc, e_op, op_mask, e_pc;
	logic [3:0]         cycles, e_cyc;
	logic               e_ld, e_push, chk_eff, chk_pc;
	logic [23:0]        e_ptr[$], seen_ptr[$];
	int                 n_errors = 0, cmp_count = 0;

	always #10 ref_clk = ~ref_clk;

	eag_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_mode(req_mode), .req_byte2(req_byte2), .req_byte3(req_byte3),
		.req_idx_width(req_idx_width), .req_rmw(req_rmw), .req_store_acc_op(req_store_acc_op),
		.req_taken(req_taken), .req_push_relative_op(req_push_relative_op),
		.req_stack_extra(req_stack_extra), .direct_base(direct_base), .index_x(index_x),
		.index_y(index_y), .stack_ptr(stack_ptr), .prog_counter(prog_counter),
		.data_bank_register(data_bank_register), .program_bank_register(program_bank_register),
		.m_flag(m_flag), .x_flag(x_flag), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
		.eff_addr(eff_addr), .operand(operand), .new_pc(new_pc), .load_pc(load_pc),
		.push_req(push_req), .cycles(cycles), .bytes(bytes));
	eag_mem_model mem_u (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_delay(mem_delay));

	always @(posedge ref_clk)
		if (rst_n && mem_req === 1'b1 && mem_ack === 1'b1)
			seen_ptr.push_back(mem_addr);

	// ****************************************
	// tasks
	// ****************************************
	function automatic logic [7:0] mb(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic pre();
		@(negedge ref_clk);
		req_mode = eag_pkg::eag_mode_e'($urandom_range(0, 12));
		{req_byte2, req_byte3, data_bank_register, program_bank_register} = $urandom;
		{direct_base, index_x} = $urandom;
		{index_y, stack_ptr} = $urandom;
		prog_counter = 16'($urandom);
		{req_idx_width, req_rmw, req_store_acc_op, req_taken, req_push_relative_op} = 5'($urandom);
		{m_flag, x_flag, req_stack_extra, mem_delay} = 7'($urandom);
	endtask

	task automatic predict();
		logic        wide, dl;
		logic [3:0]  rmwc;
		logic [15:0] p, a;
		wide = req_idx_width ? !x_flag : !m_flag;
		dl = direct_base[7:0] != 8'h00;
		rmwc = !req_rmw ? 4'h0 : (m_flag ? 4'h2 : 4'h3);
		p = direct_base + {8'h00, req_byte2};
		a = {req_byte3, req_byte2} + index_x;
		e_ptr.delete();
		{chk_eff, chk_pc, e_ld, e_push, op_mask, e_op, e_pc, e_eff} = '0;
		case (req_mode)
			eag_pkg::M_DILY, eag_pkg::M_DIL, eag_pkg::M_DI: begin
				for (int i = 0; i < ((req_mode == eag_pkg::M_DI) ? 2 : 3); i++)
					e_ptr.push_back({8'h00, p + 16'(i)});
				e_eff = {mb(p + 16'h2), mb(p + 16'h1), mb(p)};
				if (req_mode == eag_pkg::M_DI)
					e_eff[23:16] = data_bank_register;
				if (req_mode == eag_pkg::M_DILY)
					e_eff = e_eff + {8'h00, index_y};
				e_cyc = ((req_mode == eag_pkg::M_DI) ? 4'h5 : 4'h6) + 4'(wide) + 4'(dl);
				{e_byt, chk_eff} = {3'h2, 1'b1};
			end
			eag_pkg::M_DIR: {e_eff, e_cyc, e_byt, chk_eff} =
				{8'h00, p, 4'h3 + 4'(wide) + 4'(dl) + rmwc, 3'h2, 1'b1};
			eag_pkg::M_IMM: {op_mask, e_op, e_cyc, e_byt} = {wide ? 16'hffff : 16'h00ff,
				req_byte3, req_byte2, 4'h2 + 4'(wide), 3'h2 + 3'(wide)};
			eag_pkg::M_IMP: {e_cyc, e_byt, chk_eff} = {4'h2, 3'h1, 1'b1};
			eag_pkg::M_RELL: begin
				e_pc = prog_counter + {req_byte3, req_byte2};
				{e_op, op_mask, e_eff} = {e_pc, 16'hffff, program_bank_register, e_pc};
				{e_ld, e_push, chk_eff, chk_pc} =
					{!req_push_relative_op, req_push_relative_op, 2'b11};
				{e_cyc, e_byt} = {4'h3 + 4'(req_taken), 3'h3};
			end
			eag_pkg::M_REL: begin
				e_pc = prog_counter + (req_taken ? {{8{req_byte2[7]}}, req_byte2} : 16'h0);
				{e_ld, chk_pc, e_cyc, e_byt} = {req_taken, 1'b1, 4'h2 + 4'(req_taken), 3'h2};
			end
			eag_pkg::M_STK: {e_eff, e_cyc, e_byt, chk_eff} =
				{8'h00, stack_ptr, 4'h3 + 4'(req_stack_extra), 3'h1, 1'b1};
			eag_pkg::M_SR: {e_eff, e_cyc, e_byt, chk_eff} =
				{8'h00, stack_ptr + {8'h00, req_byte2}, 4'h4 + 4'(wide), 3'h2, 1'b1};
			eag_pkg::M_SRIY, eag_pkg::M_AIXJ: begin
				if (req_mode == eag_pkg::M_SRIY)
					a = stack_ptr + {8'h00, req_byte2};
				e_ptr.push_back({8'h00, a});
				e_ptr.push_back({8'h00, a + 16'h1});
				e_eff = {data_bank_register, mb(a + 16'h1), mb(a)} + {8'h00, index_y};
				chk_eff = req_mode == eag_pkg::M_SRIY;
				if (!chk_eff)
					{e_pc, e_ld, chk_pc} = {mb(a + 16'h1), mb(a), 2'b11};
				e_cyc = chk_eff ? 4'h7 + 4'(wide) : 4'h6;
				e_byt = chk_eff ? 3'h2 : 3'h3;
			end
			default: begin
				{e_eff, e_byt, chk_eff} = {data_bank_register, a, 3'h3, 1'b1};
				e_cyc = (req_store_acc_op && m_flag) ? 4'h5 :
					4'h4 + 4'(a[15:8] != req_byte3) + 4'(wide) + rmwc;
			end
		endcase
	endtask

	task automatic do_req();
		int n = 0;
		predict();
		seen_ptr.delete();
		req_valid = 1'b1;
		@(posedge ref_clk);
		#1 check(busy, 1'b1);
		// a second request while busy must be ignored
		@(negedge ref_clk) req_byte2 = ~req_byte2;
		@(negedge ref_clk) req_valid = 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#1 n++;
		end
		check(done, 1'b1);
		check(cycles, e_cyc);
		check(bytes, e_byt);
		if (chk_eff) check(eff_addr, e_eff);
		if (op_mask != 16'h0) check(operand & op_mask, e_op & op_mask);
		if (chk_pc) check({new_pc, load_pc, push_req}, {e_pc, e_ld, e_push});
		check(24'(seen_ptr.size()), 24'(e_ptr.size()));
		foreach (e_ptr[i]) if (i < seen_ptr.size()) check(seen_ptr[i], e_ptr[i]);
		@(posedge ref_clk);
		#1 check(done, 1'b0);
	endtask

	initial begin
		// ample margin over the roughly 1000 cycles the tests need
		#400000 check(1'b0, 1'b1);
		finish_test();
	end

	initial begin
		void'($urandom(32'h5e91));
		{rst_n, req_valid} = 2'b00;
		pre();
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1'b1;
		for (int m = 0; m < 13; m++) begin
			pre();
			req_mode = eag_pkg::eag_mode_e'(m);
			do_req();
		end
		$display("test all_modes ended, errors %0d", n_errors);
		for (int k = 0; k < 13; k++) begin
			pre();
			{req_rmw, m_flag, req_idx_width, req_taken, req_push_relative_op} = {3'b100, k[1:0]};
			{req_byte2, req_byte3, direct_base, index_y} = {8'hfe, 8'h12, 16'hff01, 16'hffff};
			case (k)
				0, 1: begin
					req_mode = eag_pkg::M_DIR;
					{direct_base[7:0], m_flag} = {k[7:0], !k[0]};
				end
				2, 3: req_mode = k[0] ? eag_pkg::M_DILY : eag_pkg::M_DIL;
				4, 5: begin
					req_mode = eag_pkg::M_REL;
					{req_byte2, req_taken} = {k[0] ? 8'h80 : 8'h7f, 1'b1};
				end
				6, 7: begin
					req_mode = eag_pkg::M_RELL;
					{req_byte3, req_byte2} = 16'h8000;
				end
				8: begin
					req_mode = eag_pkg::M_SR;
					{stack_ptr, req_byte2} = {16'hffff, 8'hff};
				end
				9: begin
					req_mode = eag_pkg::M_ABSX;
					{req_store_acc_op, index_x} = {1'b1, 16'h0003};
				end
				// 11 is the 8-bit store with rmw also raised: cost must stay fixed
				10, 11: begin
					req_mode = eag_pkg::M_ABSX;
					{req_store_acc_op, m_flag} = {k[0], k[0]};
				end
				default: begin
					req_mode = eag_pkg::M_STK;
					req_stack_extra = 3'h7;
				end
			endcase
			do_req();
		end
		$display("test corners ended, errors %0d", n_errors);
		repeat (150) begin
			pre();
			do_req();
		end
		$display("test random ended, errors %0d", n_errors);
		pre();
		req_mode = eag_pkg::M_DIL;
		{mem_delay, req_valid} = {2'h3, 1'b1};
		@(negedge ref_clk) req_valid = 1'b0;
		@(negedge ref_clk) rst_n = 1'b0;
		#1 check({busy, done, mem_req, load_pc, push_req, cycles, bytes}, 24'h0);
		check(eff_addr, 24'h0);
		@(negedge ref_clk) rst_n = 1'b1;
		pre();
		do_req();
		$display("test reset ended, errors %0d", n_errors);
		finish_test();
	end
endmodule
